// ===== verilog/irq_seq_defines.vh
// offsets, field positions, reset values and vector constants of the interrupt sequencer
`ifndef IRQ_SEQ_DEFINES_VH
`define IRQ_SEQ_DEFINES_VH

// register byte addresses (avalon word aligned)
`define REG_EDGE_POLARITY 6'h00
`define REG_REQUEST_1 6'h04
`define REG_REQUEST_2 6'h08
`define REG_CONTROL_1 6'h0C
`define REG_CONTROL_2 6'h10
`define REG_COLLISION_CTRL 6'h14
`define REG_SEQ_STATUS 6'h18

// edge polarity register fields
`define EDGE_EXT_A_BIT 0
`define EDGE_EXT_B_BIT 1
`define EDGE_CNT_A_BIT 2
`define EDGE_CNT_B_BIT 3
`define KEY_WAKE_SEL_BIT 4
`define EDGE_POLARITY_RESET 5'h00

// request / enable bit positions, lower index is higher priority
`define SRC_EXT_A 0
`define SRC_EXT_B_KEY 1
`define SRC_CNT_A 2
`define SRC_CNT_B 3
`define SRC_TIMER_X 4
`define SRC_TIMER_Y 5
`define SRC_TIMER_1 6
`define SRC_TIMER_2 7
`define SRC_RX 8
`define SRC_TX 9
`define SRC_ARB 10
`define SRC_ADC 11
`define SRC_COUNT 4'hC
`define REQUEST_RESET 12'h000
`define ENABLE_RESET 12'h000
`define COLLISION_RESET 1'b0

// vectors: low byte address of source i is VECTOR_TOP - 2*i
`define VECTOR_TOP 16'hFFFC
`define BREAK_VECTOR 16'hFFE4
`define BREAK_PC_STEP 16'h0002
`define BREAK_FLAG_BIT 4

`endif

// ===== verilog/vectored_interrupt_sequencer.v
// fixed-priority vectored interrupt sequencer with avalon-mm register slave
// Function
// R1 - key select set and stop/wait mode: any low key input raises key wakeup request
// R2 - outside stop/wait the key wakeup source raises no request
// R3 - key wakeup and external b share request bit, enable bit, vector; select picks
// R4 - low key input when stop/wait executes raises key request at once
// R5 - each counter pin requests on rising or falling edge per its select bit
// R6 - edge select bits reset to 0 (falling); enables reset 0, disable flag 1
// R7 - counter pin edge detection runs always; software keeps enables 0 for ports
// R8 - each timer underflow sets that timer's request bit
// R9 - received word moving into receive buffer raises receive request
// R10 - transmit buffer empty or shift finished raises transmit request
// R11 - collision enable and txd/rxd mismatch during serial use raises arbitration request
// R12 - conversion complete raises converter request
// R13 - every hardware request sets its request bit to 1
// R14 - hardware request accepted only if enable is 1 and disable flag is 0
// R15 - break sets break flag and is accepted regardless of enables and flag
// R16 - current instruction completes before program flow is suspended
// R17 - push pc high byte, then pc low byte, then status
// R18 - load vector into pc, set disable flag, clear request except for break
// R19 - return pulls status, pc low, pc high, then resumes at restored address
// R20 - break adds 2 to pc before pushing it
// R21 - order: finish instruction, pipeline post-processing, pushes, vector fetch
// R22 - simultaneous acceptable requests: highest fixed priority wins
// R23 - software writes may clear request bits but never set them
// R24 - unaccepted request stays set until accepted or cleared by software
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_seq_defines.vh"

module vectored_interrupt_sequencer (
   input wire clk,
   input wire arst_n,
   // avalon-mm slave
   input wire [5:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest,
   // interrupt sources
   input wire external_irq_a,
   input wire external_irq_b,
   input wire counter_pin_a,
   input wire counter_pin_b,
   input wire [7:0] key_port,
   input wire [7:0] key_port_is_input,
   input wire [3:0] timer_underflow,
   input wire rx_word_moved,
   input wire tx_buffer_empty,
   input wire tx_shift_done,
   input wire serial_active,
   input wire txd_level,
   input wire rxd_level,
   input wire adc_done,
   // cpu core side
   input wire stop_wait_mode,
   input wire stop_instruction,
   input wire wait_instruction,
   input wire instr_done,
   input wire break_instruction,
   input wire return_from_irq_instruction,
   input wire disable_flag,
   input wire [15:0] pc_in,
   input wire [7:0] status_in,
   input wire [7:0] stack_rdata,
   input wire [7:0] vector_rdata,
   output reg seq_busy,
   output reg stack_push,
   output reg stack_pull,
   output reg [7:0] stack_wdata,
   output reg vector_rd,
   output reg [15:0] vector_addr,
   output reg pc_load,
   output reg [15:0] pc_value,
   output reg status_load,
   output reg [7:0] status_value,
   output reg set_disable,
   output reg set_break,
   output reg wake_request
);

   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_POST = 4'h1;
   localparam [3:0] ST_PUSH_H = 4'h2;
   localparam [3:0] ST_PUSH_L = 4'h3;
   localparam [3:0] ST_PUSH_P = 4'h4;
   localparam [3:0] ST_VEC_L = 4'h5;
   localparam [3:0] ST_VEC_H = 4'h6;
   localparam [3:0] ST_LOAD = 4'h7;
   localparam [3:0] ST_PULL_P = 4'h8;
   localparam [3:0] ST_PULL_L = 4'h9;
   localparam [3:0] ST_PULL_H = 4'hA;
   localparam [3:0] ST_RLOAD = 4'hB;

   // index of the highest priority set bit; SRC_COUNT when none
   function [3:0] top_source;
      input [11:0] bits;
      integer i;
      begin
         top_source = `SRC_COUNT;
         for (i = `SRC_COUNT - 1; i >= 0; i = i - 1) begin
            if (bits[i]) begin
               top_source = i[3:0];
            end
         end
      end
   endfunction

   function [15:0] vector_of;
      input [3:0] src;
      begin
         vector_of = `VECTOR_TOP - {11'h000, src, 1'b0};
      end
   endfunction

   function edge_seen;
      input prev;
      input now;
      input rising;
      begin
         edge_seen = rising ? (!prev && now) : (prev && !now);
      end
   endfunction

   reg [4:0] edge_polarity;
   reg [11:0] request;
   reg [11:0] enable;
   reg collision_en;
   reg [3:0] pin_prev;
   reg edges_armed;
   reg [3:0] state;
   reg [3:0] accepted_src;
   reg is_break;
   reg [15:0] saved_pc;
   reg [7:0] saved_status;
   reg [7:0] low_byte;

   wire key_sel = edge_polarity[`KEY_WAKE_SEL_BIT];
   wire in_stop_wait = stop_wait_mode || stop_instruction || wait_instruction;
   wire key_low = |(~key_port & key_port_is_input);
   wire key_event = key_sel && in_stop_wait && key_low; // R1 R2 R4
   wire ext_a_edge = edges_armed &&
      edge_seen(pin_prev[0], external_irq_a, edge_polarity[`EDGE_EXT_A_BIT]);
   wire ext_b_edge = edges_armed &&
      edge_seen(pin_prev[1], external_irq_b, edge_polarity[`EDGE_EXT_B_BIT]);
   // counter edges are detected whatever the pin's port role
   wire cnt_a_edge = edges_armed &&
      edge_seen(pin_prev[2], counter_pin_a, edge_polarity[`EDGE_CNT_A_BIT]); // R5 R7
   wire cnt_b_edge = edges_armed &&
      edge_seen(pin_prev[3], counter_pin_b, edge_polarity[`EDGE_CNT_B_BIT]); // R5 R7
   wire collision = collision_en && serial_active && (txd_level != rxd_level); // R11

   reg [11:0] hw_set;
   always @* begin
      hw_set = 12'h000;
      hw_set[`SRC_EXT_A] = ext_a_edge;
      hw_set[`SRC_EXT_B_KEY] = key_sel ? key_event : ext_b_edge; // R3
      hw_set[`SRC_CNT_A] = cnt_a_edge;
      hw_set[`SRC_CNT_B] = cnt_b_edge;
      hw_set[`SRC_TIMER_X] = timer_underflow[0]; // R8
      hw_set[`SRC_TIMER_Y] = timer_underflow[1]; // R8
      hw_set[`SRC_TIMER_1] = timer_underflow[2]; // R8
      hw_set[`SRC_TIMER_2] = timer_underflow[3]; // R8
      hw_set[`SRC_RX] = rx_word_moved; // R9
      hw_set[`SRC_TX] = tx_buffer_empty || tx_shift_done; // R10
      hw_set[`SRC_ARB] = collision; // R11
      hw_set[`SRC_ADC] = adc_done; // R12
   end

   wire [11:0] pending = request & enable;
   wire [3:0] top_pending = top_source(pending); // R22
   wire can_accept = (pending != 12'h000) && !disable_flag; // R14
   wire start_break = (state == ST_IDLE) && instr_done && break_instruction; // R15 R16
   wire start_irq = (state == ST_IDLE) && instr_done && !break_instruction &&
      !return_from_irq_instruction && can_accept; // R16
   wire start_rti = (state == ST_IDLE) && instr_done && !break_instruction &&
      return_from_irq_instruction;

   wire sw_write = write && !waitrequest;

   // software clear mask: a written 1 keeps, a written 0 clears
   reg [11:0] sw_keep;
   always @* begin
      sw_keep = 12'hFFF;
      if (sw_write && address == `REG_REQUEST_1) begin
         sw_keep[7:0] = writedata[7:0]; // R23
      end
      if (sw_write && address == `REG_REQUEST_2) begin
         sw_keep[11:8] = writedata[3:0]; // R23
      end
   end

   // acceptance clears its own bit; break leaves the bits alone
   reg [11:0] accept_clear;
   always @* begin
      accept_clear = 12'h000;
      if (state == ST_LOAD && !is_break && accepted_src != `SRC_COUNT) begin
         accept_clear[accepted_src] = 1'b1; // R18
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         request <= `REQUEST_RESET;
      end else begin
         // set wins over both clears, so no event is lost
         request <= (request & sw_keep & ~accept_clear) | hw_set; // R13 R24
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_prev <= 4'h0;
         edges_armed <= 1'b0;
      end else begin
         pin_prev <= {counter_pin_b, counter_pin_a, external_irq_b, external_irq_a};
         // first sample after reset only primes the history
         edges_armed <= 1'b1;
      end
   end

   // register slave: one wait cycle, then the access completes
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
         edge_polarity <= `EDGE_POLARITY_RESET; // R6
         enable <= `ENABLE_RESET; // R6
         collision_en <= `COLLISION_RESET;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
         if ((read || write) && waitrequest) begin
            case (address)
               `REG_EDGE_POLARITY: readdata <= {27'h0, edge_polarity};
               `REG_REQUEST_1: readdata <= {24'h0, request[7:0]};
               `REG_REQUEST_2: readdata <= {28'h0, request[11:8]};
               `REG_CONTROL_1: readdata <= {24'h0, enable[7:0]};
               `REG_CONTROL_2: readdata <= {28'h0, enable[11:8]};
               `REG_COLLISION_CTRL: readdata <= {31'h0, collision_en};
               `REG_SEQ_STATUS: readdata <= {19'h0, is_break, accepted_src, 4'h0, state};
               default: readdata <= 32'h0000_0000;
            endcase
         end
         if (sw_write) begin
            case (address)
               `REG_EDGE_POLARITY: edge_polarity <= writedata[4:0];
               `REG_CONTROL_1: enable[7:0] <= writedata[7:0];
               `REG_CONTROL_2: enable[11:8] <= writedata[3:0];
               `REG_COLLISION_CTRL: collision_en <= writedata[0];
               default: collision_en <= collision_en;
            endcase
         end
      end
   end

   // sequencer towards the cpu core
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         accepted_src <= `SRC_COUNT;
         is_break <= 1'b0;
         saved_pc <= 16'h0000;
         saved_status <= 8'h00;
         low_byte <= 8'h00;
         seq_busy <= 1'b0;
         stack_push <= 1'b0;
         stack_pull <= 1'b0;
         stack_wdata <= 8'h00;
         vector_rd <= 1'b0;
         vector_addr <= 16'h0000;
         pc_load <= 1'b0;
         pc_value <= 16'h0000;
         status_load <= 1'b0;
         status_value <= 8'h00;
         set_disable <= 1'b0;
         set_break <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         stack_push <= 1'b0;
         stack_pull <= 1'b0;
         vector_rd <= 1'b0;
         pc_load <= 1'b0;
         status_load <= 1'b0;
         set_disable <= 1'b0;
         set_break <= 1'b0;
         // enabled pending request ends stop/wait regardless of the flag
         wake_request <= (pending != 12'h000);
         case (state)
            ST_IDLE: begin
               seq_busy <= start_break || start_irq || start_rti;
               if (start_break) begin
                  is_break <= 1'b1;
                  // with masked requests pending, break takes the best of their vectors
                  accepted_src <= top_pending;
                  saved_pc <= pc_in + `BREAK_PC_STEP; // R20
                  saved_status <= status_in | (8'h01 << `BREAK_FLAG_BIT); // R15
                  set_break <= 1'b1; // R15
                  state <= ST_POST;
               end else if (start_irq) begin
                  is_break <= 1'b0;
                  accepted_src <= top_pending; // R22
                  saved_pc <= pc_in;
                  saved_status <= status_in;
                  state <= ST_POST;
               end else if (start_rti) begin
                  stack_pull <= 1'b1; // R19
                  state <= ST_PULL_P;
               end
            end
            ST_POST: begin
               // pipeline post-processing slot before any push
               state <= ST_PUSH_H; // R21
            end
            ST_PUSH_H: begin
               stack_push <= 1'b1;
               stack_wdata <= saved_pc[15:8]; // R17
               state <= ST_PUSH_L;
            end
            ST_PUSH_L: begin
               stack_push <= 1'b1;
               stack_wdata <= saved_pc[7:0]; // R17
               state <= ST_PUSH_P;
            end
            ST_PUSH_P: begin
               stack_push <= 1'b1;
               stack_wdata <= saved_status; // R17
               state <= ST_VEC_L;
            end
            ST_VEC_L: begin
               vector_rd <= 1'b1;
               vector_addr <= (accepted_src == `SRC_COUNT) ? `BREAK_VECTOR :
                  vector_of(accepted_src); // R21
               state <= ST_VEC_H;
            end
            ST_VEC_H: begin
               low_byte <= vector_rdata;
               vector_rd <= 1'b1;
               vector_addr <= vector_addr + 16'h0001;
               state <= ST_LOAD;
            end
            ST_LOAD: begin
               pc_load <= 1'b1;
               pc_value <= {vector_rdata, low_byte}; // R18
               set_disable <= 1'b1; // R18
               seq_busy <= 1'b0;
               state <= ST_IDLE;
            end
            ST_PULL_P: begin
               stack_pull <= 1'b1;
               state <= ST_PULL_L;
            end
            ST_PULL_L: begin
               status_value <= stack_rdata; // R19
               stack_pull <= 1'b1;
               state <= ST_PULL_H;
            end
            ST_PULL_H: begin
               low_byte <= stack_rdata; // R19
               state <= ST_RLOAD;
            end
            ST_RLOAD: begin
               pc_value <= {stack_rdata, low_byte}; // R19
               pc_load <= 1'b1;
               status_load <= 1'b1;
               seq_busy <= 1'b0;
               state <= ST_IDLE;
            end
            default: begin
               seq_busy <= 1'b0;
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== testbench/irq_seq_checker.sv
// port-level assertions for the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module irq_seq_checker (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire logic instr_done,
   input wire logic break_instruction,
   input wire logic return_from_irq_instruction,
   input wire logic disable_flag,
   input wire logic [15:0] pc_in,
   input wire logic seq_busy,
   input wire logic stack_push,
   input wire logic stack_pull,
   input wire logic [7:0] stack_wdata,
   input wire logic vector_rd,
   input wire logic [15:0] vector_addr,
   input wire logic pc_load,
   input wire logic status_load,
   input wire logic set_disable,
   input wire logic set_break
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [15:0] brk_pc;
   logic [7:0] brk_hi;
   logic idle_do;
   logic brk_do;
   assign brk_pc = pc_in + 16'h0002;
   assign brk_hi = brk_pc[15:8];
   assign idle_do = instr_done && !seq_busy;
   assign brk_do = idle_do && break_instruction;
   bus_wait_a: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest
      ##1 waitrequest) else $error("bus wait cycle count wrong");
   brk_take_a: assert property (brk_do |=> seq_busy && set_break)
      else $error("break not taken at once");
   brk_flag_only_a: assert property ($rose(set_break) |-> $past(brk_do))
      else $error("break flag without break");
   brk_push_a: assert property (brk_do |-> ##3 stack_push
      && stack_wdata == $past(brk_hi, 3)) else $error("break pushed wrong high byte");
   push_seq_a: assert property ($rose(stack_push) |-> ##1 stack_push ##1 stack_push
      ##1 (vector_rd && !stack_push)) else $error("push and fetch order wrong");
   vec_pair_a: assert property ($rose(vector_rd) |=> vector_rd
      && vector_addr == $past(vector_addr) + 16'h0001 ##1 pc_load && set_disable && !seq_busy)
      else $error("vector fetch or load wrong");
   masked_idle_a: assert property (idle_do && disable_flag && !break_instruction
      && !return_from_irq_instruction |=> !seq_busy) else $error("masked request taken");
   rti_pull_a: assert property (idle_do && return_from_irq_instruction && !break_instruction
      |=> stack_pull[*3] ##1 !stack_pull ##[0:2] (pc_load && status_load))
      else $error("return pulls wrong");
endmodule
bind vectored_interrupt_sequencer irq_seq_checker chk_i (.clk, .arst_n, .read, .write,
   .waitrequest, .instr_done, .break_instruction, .return_from_irq_instruction, .disable_flag,
   .pc_in, .seq_busy, .stack_push, .stack_pull, .stack_wdata, .vector_rd, .vector_addr,
   .pc_load, .status_load, .set_disable, .set_break);
`default_nettype wire

// ===== testbench/cpu_core_model.sv
// behavioural cpu side: stack memory and vector table
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
   input wire logic clk,
   input wire logic stack_push,
   input wire logic [7:0] stack_wdata,
   input wire logic stack_pull,
   output var logic [7:0] stack_rdata,
   input wire logic vector_rd,
   input wire logic [15:0] vector_addr,
   output var logic [7:0] vector_rdata
);
   logic [7:0] mem [256];
   logic [7:0] sp = 8'hFF;
   initial stack_rdata = 8'h00;
   always @(posedge clk) begin
      if (stack_push) begin
         mem[sp] <= stack_wdata;
         sp <= sp - 8'h01;
      end
      // bytes valid one cycle only; toggling keeps stale data from matching
      if (stack_pull) begin
         stack_rdata <= mem[sp + 8'h01];
         sp <= sp + 8'h01;
      end else
         stack_rdata <= ~stack_rdata;
   end
   // table answers within the strobe cycle; the inverse otherwise, so a late sample misses
   always_comb
      vector_rdata = vector_rd ? (vector_addr[7:0] ^ 8'h5A) : ~(vector_addr[7:0] ^ 8'h5A);
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the vectored interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, arst_n, read, write, waitrequest, external_irq_a, external_irq_b;
   logic counter_pin_a, counter_pin_b, rx_word_moved, tx_buffer_empty, tx_shift_done;
   logic serial_active, txd_level, rxd_level, adc_done, stop_wait_mode, instr_done;
   logic break_instruction, return_from_irq_instruction, disable_flag, seq_busy;
   logic stack_push, stack_pull, vector_rd, pc_load, status_load;
   logic stop_instruction, wait_instruction, wake_request;
   logic [5:0] address;
   logic [31:0] writedata, readdata, q;
   logic [7:0] key_port, key_port_is_input, status_in, stack_rdata, vector_rdata;
   logic [7:0] stack_wdata, status_value;
   logic [3:0] timer_underflow;
   logic [15:0] pc_in, vector_addr, pc_value;
   int num_errors = 0;
   int n_checks = 0;
   int i;
   int src [11] = '{0, 1, 3, 4, 5, 6, 7, 8, 9, 10, 11};
   vectored_interrupt_sequencer dut (.clk, .arst_n, .address, .read, .write, .writedata,
      .readdata, .waitrequest, .external_irq_a, .external_irq_b, .counter_pin_a,
      .counter_pin_b, .key_port, .key_port_is_input, .timer_underflow, .rx_word_moved,
      .tx_buffer_empty, .tx_shift_done, .serial_active, .txd_level, .rxd_level, .adc_done,
      .stop_wait_mode, .stop_instruction, .wait_instruction, .instr_done,
      .break_instruction, .return_from_irq_instruction, .disable_flag, .pc_in, .status_in,
      .stack_rdata, .vector_rdata, .seq_busy, .stack_push, .stack_pull, .stack_wdata,
      .vector_rd, .vector_addr, .pc_load, .pc_value, .status_load, .status_value,
      .set_disable(), .set_break(), .wake_request);
   cpu_core_model cpu (.clk, .stack_push, .stack_wdata, .stack_pull, .stack_rdata,
      .vector_rd, .vector_addr, .vector_rdata);
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 40);
      if (k >= 40) begin
         num_errors++;
         close_out;
      end
      q = readdata;
      read <= 0;
      write <= 0;
   endtask
   task rd(input logic [5:0] a, input logic [31:0] e);
      bus(0, a, 0);
      chk(q, e);
   endtask
   // one completing instruction; q holds status and pc of the load, or all ones
   task run(input logic b, input logic r, input logic [15:0] p, input logic [7:0] s);
      @(posedge clk);
      instr_done <= 1;
      break_instruction <= b;
      return_from_irq_instruction <= r;
      pc_in <= p;
      status_in <= s;
      @(posedge clk);
      instr_done <= 0;
      break_instruction <= 0;
      return_from_irq_instruction <= 0;
      q = '1;
      for (int k = 0; k < 16 && q === '1; k++) begin
         @(posedge clk);
         if (pc_load === 1'b1)
            q = {8'h00, status_value, pc_value};
      end
   endtask
   function logic [15:0] vec(input logic [15:0] lo);
      return {lo[7:0] ^ 8'h5B, lo[7:0] ^ 8'h5A};
   endfunction
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      close_out;
   end
   initial begin
      {arst_n, read, write, address, writedata, timer_underflow, instr_done} = '0;
      {rx_word_moved, tx_buffer_empty, tx_shift_done, serial_active, adc_done} = '0;
      {break_instruction, return_from_irq_instruction, stop_wait_mode, pc_in} = '0;
      {stop_instruction, wait_instruction} = 2'b00;
      {external_irq_a, external_irq_b, counter_pin_a, counter_pin_b} = 4'hF;
      {txd_level, rxd_level, disable_flag, status_in} = {3'b111, 8'h00};
      key_port = 8'hFF;
      key_port_is_input = 8'hFF;
      repeat (20) @(posedge clk);
      arst_n <= 1;
      for (i = 0; i < 6; i++)
         rd(6'(i * 4), 0);
      rd(6'h1C, 0);
      $display("reset test done");
      counter_pin_a <= 0;
      repeat (3) @(posedge clk);
      rd(6'h04, 32'h04);
      run(0, 0, 16'h1000, 8'h00);
      chk(q, '1);
      bus(1, 6'h04, 32'hFF);
      rd(6'h04, 32'h04);
      bus(1, 6'h00, 32'h08);
      bus(1, 6'h04, 32'h00);
      rd(6'h04, 32'h00);
      counter_pin_b <= 0;
      external_irq_a <= 0;
      repeat (3) @(posedge clk);
      counter_pin_b <= 1;
      repeat (3) @(posedge clk);
      rd(6'h04, 32'h09);
      $display("edge test done");
      bus(1, 6'h00, 32'h18);
      key_port <= 8'hFE;
      repeat (4) @(posedge clk);
      rd(6'h04, 32'h09);
      stop_wait_mode <= 1;
      repeat (4) @(posedge clk);
      stop_wait_mode <= 0;
      key_port <= 8'hFF;
      rd(6'h04, 32'h0B);
      // a low key at the instruction pulse alone must raise the shared request
      for (i = 0; i < 2; i++) begin
         bus(1, 6'h04, 32'hFD);
         rd(6'h04, 32'h09);
         key_port <= 8'hFE;
         {stop_instruction, wait_instruction} <= 2'(i + 1);
         @(posedge clk);
         {stop_instruction, wait_instruction} <= 2'b00;
         key_port <= 8'hFF;
         rd(6'h04, 32'h0B);
      end
      $display("key test done");
      bus(1, 6'h14, 32'h01);
      timer_underflow <= 4'hF;
      {rx_word_moved, tx_shift_done, adc_done, serial_active, rxd_level} <= 5'b11110;
      @(posedge clk);
      timer_underflow <= 4'h0;
      {rx_word_moved, tx_shift_done, adc_done, serial_active, rxd_level} <= 5'b00001;
      repeat (2) @(posedge clk);
      rd(6'h04, 32'hFB);
      rd(6'h08, 32'h0F);
      $display("source test done");
      bus(1, 6'h0C, 32'hFF);
      bus(1, 6'h10, 32'h0F);
      run(0, 0, 16'h1000, 8'h00);
      chk(q, '1);
      chk({31'h0, wake_request}, 32'h1);
      disable_flag <= 0;
      for (i = 0; i < 11; i++) begin
         run(0, 0, 16'h1234 + 16'(i), 8'h21);
         chk({16'h0000, q[15:0]}, {16'h0000, vec(16'hFFFC - 16'(2 * src[i]))});
         run(0, 1, 16'h2000, 8'h00);
         chk(q, {16'h0021, 16'h1234 + 16'(i)});
      end
      rd(6'h04, 32'h00);
      rd(6'h08, 32'h00);
      chk({31'h0, wake_request}, 32'h0);
      $display("priority test done");
      disable_flag <= 1;
      run(1, 0, 16'h4000, 8'h00);
      chk({16'h0000, q[15:0]}, {16'h0000, vec(16'hFFE4)});
      run(0, 1, 16'h2000, 8'h00);
      chk(q, {16'h0010, 16'h4002});
      $display("break test done");
      close_out;
   end
endmodule
`default_nettype wire
